/* include/ata_rd_pkg.sv */
// Package with register map, command codes, fields and types for the read command engine
package ata_rd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register word offsets (index); byte address is four times the index
  localparam logic [3:0] REG_DATA    = 4'h0;
  localparam logic [3:0] REG_FEATURE = 4'h1;
  localparam logic [3:0] REG_SECCNT  = 4'h2;
  localparam logic [3:0] REG_SECNUM  = 4'h3;
  localparam logic [3:0] REG_CYLLO   = 4'h4;
  localparam logic [3:0] REG_CYLHI   = 4'h5;
  localparam logic [3:0] REG_DRVHD   = 4'h6;
  localparam logic [3:0] REG_CMD     = 4'h7;
  localparam logic [3:0] REG_CTRL    = 4'h8;
  localparam logic [3:0] REG_ERROR   = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_RD_BUF   = 8'hE4;
  localparam logic [7:0] CMD_RD_DMA   = 8'hC8;
  localparam logic [7:0] CMD_RD_LONG0 = 8'h22;
  localparam logic [7:0] CMD_RD_LONG1 = 8'h23;
  localparam logic [7:0] CMD_RD_MULT  = 8'hC4;
  localparam logic [7:0] CMD_RD_SEC0  = 8'h20;
  localparam logic [7:0] CMD_RD_SEC1  = 8'h21;
  localparam logic [7:0] CMD_VERIFY0  = 8'h40;
  localparam logic [7:0] CMD_VERIFY1  = 8'h41;
  localparam logic [3:0] CMD_RECAL_HI = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Status bits, error bits, control fields
  localparam int ST_BSY  = 7;
  localparam int ST_DRQ  = 3;
  localparam int ST_CORR = 2;
  localparam int ST_ERR  = 0;
  localparam int ER_UNC  = 6;
  localparam int ER_ABRT = 2;
  localparam int CT_BYTE_MODE = 0;
  localparam int CT_MULT_EN   = 1;
  localparam int CT_BLK_LSB   = 8;
  localparam int DH_LBA  = 6;
  localparam int DH_DRV  = 4;
  localparam logic [7:0] DH_FIXED = 8'hA0;
  localparam logic [7:0] CTRL_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sizes
  localparam logic [8:0] SECTOR_WORDS = 9'h100;
  localparam logic [8:0] ECC_BYTES    = 9'h004;
  localparam logic [8:0] FULL_COUNT   = 9'h100;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_XFER  = 3'b011,
    ST_ECC   = 3'b010,
    ST_DONE  = 3'b110
  } state_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_PIO, OP_BUF, OP_LONG, OP_DMA, OP_MULT, OP_VERIFY
  } op_t;

  typedef struct packed {
    logic        req;
    logic [27:0] lba;
  } media_req_t;

  typedef struct packed {
    logic       done;
    logic       corr_err;
    logic       unc_err;
  } media_rsp_t;

endpackage

/* rtl/ata_word_mux.sv */
// Data word source selection: sector words, then ECC bytes in the low byte lane
`timescale 1ns/10ps
`default_nettype none
module ata_word_mux
(
  // Sector data and ECC from the media buffer
  input  wire logic [15:0] i_sector_word,
  input  wire logic [31:0] i_ecc,
  // Selection
  input  wire logic        i_ecc_phase,
  input  wire logic [1:0]  i_ecc_idx,
  // Result
  output logic      [15:0] o_word
);

  // ECC goes out one byte at a time in the low lane, upper lane zero
  always_comb
  begin
    if (i_ecc_phase)
      o_word = {8'h00, i_ecc[{i_ecc_idx, 3'b000} +: 8]};
    else
      o_word = i_sector_word;
  end

endmodule // ata_word_mux
`default_nettype wire

/* rtl/ata_read_command_engine.sv */
// Read command interpreter with task file on a classic Wishbone slave
`timescale 1ns/10ps
`default_nettype none
module ata_read_command_engine
#(
  parameter int MAX_BLOCK = 128
)
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // Wishbone slave
  input  wire logic                   i_wb_cyc,
  input  wire logic                   i_wb_stb,
  input  wire logic                   i_wb_we,
  input  wire logic [5:0]             i_wb_adr,
  input  wire logic [3:0]             i_wb_sel,
  input  wire logic [31:0]            i_wb_dat,
  output logic      [31:0]            o_wb_dat,
  output logic                        o_wb_ack,
  // Media side
  output ata_rd_pkg::media_req_t      o_media,
  input  wire ata_rd_pkg::media_rsp_t i_media,
  input  wire logic [15:0]            i_sector_word,
  input  wire logic [31:0]            i_ecc,
  output logic      [7:0]             o_word_idx,
  // DMA pins
  output logic                        o_dmareq,
  input  wire logic                   i_dmack_n,
  input  wire logic                   i_iord_n,
  output logic      [15:0]            o_dma_dat,
  // Interrupt to host
  output logic                        o_intrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (MAX_BLOCK < 1 || MAX_BLOCK > 255)
    $error("MAX_BLOCK must be 1 to 255");

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ata_rd_pkg::state_t state_r;
  ata_rd_pkg::op_t    op_r;
  logic [7:0]  feature_r, seccnt_r, secnum_r, cyllo_r, cylhi_r, drvhd_r;
  logic [7:0]  status_r, error_r, ctrl_r, blk_size_r;
  logic        blk_set_r;
  logic [8:0]  remain_r;
  logic [8:0]  blk_left_r;
  logic [8:0]  words_left_r;
  logic [1:0]  ecc_idx_r;
  logic [7:0]  word_idx_r;
  logic        stop_r;
  logic        media_req_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic        intrq_r;
  logic        dmareq_r;
  logic [15:0] dma_dat_r;
  logic [2:0]  dmack_sync_r, iord_sync_r;
  logic [15:0] word_mux;
  logic        wb_req, wr_cmd, rd_data, dma_strobe, word_take, first_sec;
  logic [27:0] lba;
  logic [8:0]  cnt_full;
  logic [7:0]  cmd_code;

  assign wb_req   = i_wb_cyc && i_wb_stb && !ack_r;
  assign cmd_code = i_wb_dat[7:0];
  assign wr_cmd   = wb_req && i_wb_we && i_wb_sel[0] && (i_wb_adr[5:2] == ata_rd_pkg::REG_CMD);
  assign rd_data  = wb_req && !i_wb_we && (i_wb_adr[5:2] == ata_rd_pkg::REG_DATA);
  assign lba      = {drvhd_r[3:0], cylhi_r, cyllo_r, secnum_r};
  assign cnt_full = (seccnt_r == 8'h00) ? ata_rd_pkg::FULL_COUNT : {1'b0, seccnt_r};

  // Decode a command code into an operation, used at acceptance
  function automatic ata_rd_pkg::op_t decode_op(input logic [7:0] c);
    case (c)
      ata_rd_pkg::CMD_RD_BUF:   decode_op = ata_rd_pkg::OP_BUF;
      ata_rd_pkg::CMD_RD_DMA:   decode_op = ata_rd_pkg::OP_DMA;
      ata_rd_pkg::CMD_RD_LONG0,
      ata_rd_pkg::CMD_RD_LONG1: decode_op = ata_rd_pkg::OP_LONG;
      ata_rd_pkg::CMD_RD_MULT:  decode_op = ata_rd_pkg::OP_MULT;
      ata_rd_pkg::CMD_RD_SEC0,
      ata_rd_pkg::CMD_RD_SEC1:  decode_op = ata_rd_pkg::OP_PIO;
      ata_rd_pkg::CMD_VERIFY0,
      ata_rd_pkg::CMD_VERIFY1:  decode_op = ata_rd_pkg::OP_VERIFY;
      default:                  decode_op = ata_rd_pkg::OP_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage is read only by the second
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dmack_sync_r <= 3'b111;
      iord_sync_r  <= 3'b111;
    end
    else
    begin
      dmack_sync_r <= {dmack_sync_r[1:0], i_dmack_n};
      iord_sync_r  <= {iord_sync_r[1:0], i_iord_n};
    end
  end

  // Read strobe edge while acknowledged: one word moves per pulse
  assign dma_strobe = dmareq_r && !dmack_sync_r[1] && iord_sync_r[2] && !iord_sync_r[1];
  assign word_take  = (state_r == ata_rd_pkg::ST_XFER || state_r == ata_rd_pkg::ST_ECC)
                    && status_r[ata_rd_pkg::ST_DRQ]
                    && ((op_r == ata_rd_pkg::OP_DMA) ? dma_strobe : rd_data);
  assign first_sec  = (blk_left_r == 9'h000);

  ////////////////////////////////////////////////////////////////////////////
  // Data word selection
  ata_word_mux u_word_mux
  (
    .i_sector_word (i_sector_word),
    .i_ecc         (i_ecc),
    .i_ecc_phase   (state_r == ata_rd_pkg::ST_ECC),
    .i_ecc_idx     (ecc_idx_r),
    .o_word        (word_mux)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone acknowledge, one cycle after the request, dropped next cycle
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= wb_req;
  end

  // Read data mux; unmapped addresses read zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdat_r <= 32'h0000_0000;
    else if (wb_req && !i_wb_we)
    begin
      case (i_wb_adr[5:2])
        ata_rd_pkg::REG_DATA:    rdat_r <= {16'h0000, word_mux};
        ata_rd_pkg::REG_FEATURE: rdat_r <= {24'h000000, feature_r};
        ata_rd_pkg::REG_SECCNT:  rdat_r <= {24'h000000, seccnt_r};
        ata_rd_pkg::REG_SECNUM:  rdat_r <= {24'h000000, secnum_r};
        ata_rd_pkg::REG_CYLLO:   rdat_r <= {24'h000000, cyllo_r};
        ata_rd_pkg::REG_CYLHI:   rdat_r <= {24'h000000, cylhi_r};
        ata_rd_pkg::REG_DRVHD:   rdat_r <= {24'h000000, drvhd_r};
        ata_rd_pkg::REG_CMD:     rdat_r <= {24'h000000, status_r};
        ata_rd_pkg::REG_CTRL:    rdat_r <= {16'h0000, blk_size_r, ctrl_r};
        ata_rd_pkg::REG_ERROR:   rdat_r <= {24'h000000, error_r};
        default:                 rdat_r <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register: byte mode, multiple enable, block size
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_r     <= ata_rd_pkg::CTRL_RST;
      blk_size_r <= 8'h00;
      blk_set_r  <= 1'b0;
    end
    else if (wb_req && i_wb_we && (i_wb_adr[5:2] == ata_rd_pkg::REG_CTRL)
             && !status_r[ata_rd_pkg::ST_BSY])
    begin
      if (i_wb_sel[0])
        ctrl_r <= i_wb_dat[7:0];
      if (i_wb_sel[1] && i_wb_dat[15:8] != 8'h00 && i_wb_dat[15:8] <= 8'(MAX_BLOCK))
      begin
        blk_size_r <= i_wb_dat[15:8];
        blk_set_r  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Task file: host writes while not busy, engine steps the address
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      feature_r <= 8'h00;
      seccnt_r  <= 8'h01;
      secnum_r  <= 8'h01;
      cyllo_r   <= 8'h00;
      cylhi_r   <= 8'h00;
      drvhd_r   <= ata_rd_pkg::DH_FIXED;
    end
    else if (wb_req && i_wb_we && !status_r[ata_rd_pkg::ST_BSY] && i_wb_sel[0])
    begin
      case (i_wb_adr[5:2])
        ata_rd_pkg::REG_FEATURE: feature_r <= i_wb_dat[7:0];
        ata_rd_pkg::REG_SECCNT:  seccnt_r  <= i_wb_dat[7:0];
        ata_rd_pkg::REG_SECNUM:  secnum_r  <= i_wb_dat[7:0];
        ata_rd_pkg::REG_CYLLO:   cyllo_r   <= i_wb_dat[7:0];
        ata_rd_pkg::REG_CYLHI:   cylhi_r   <= i_wb_dat[7:0];
        ata_rd_pkg::REG_DRVHD:   drvhd_r   <= i_wb_dat[7:0] | ata_rd_pkg::DH_FIXED;
        default:                 ;
      endcase
    end
    else if (state_r == ata_rd_pkg::ST_FETCH && i_media.done && !i_media.unc_err
             && remain_r > 9'h001 && op_r != ata_rd_pkg::OP_BUF)
    begin
      // Step to the next sector; on the last one the address stays put
      {drvhd_r[3:0], cylhi_r, cyllo_r, secnum_r} <= lba + 28'h0000001;
    end
    else if (state_r == ata_rd_pkg::ST_FETCH && i_media.done && i_media.unc_err
             && op_r == ata_rd_pkg::OP_VERIFY)
      seccnt_r <= remain_r[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r      <= ata_rd_pkg::ST_IDLE;
      op_r         <= ata_rd_pkg::OP_NONE;
      status_r     <= 8'h00;
      error_r      <= 8'h00;
      remain_r     <= 9'h000;
      blk_left_r   <= 9'h000;
      words_left_r <= 9'h000;
      ecc_idx_r    <= 2'b00;
      stop_r       <= 1'b0;
      media_req_r  <= 1'b0;
      intrq_r      <= 1'b0;
      dmareq_r     <= 1'b0;
    end
    else
    begin
      media_req_r <= 1'b0;
      // Reading status acknowledges the interrupt; a new one in the same cycle wins
      if (wb_req && !i_wb_we && i_wb_adr[5:2] == ata_rd_pkg::REG_CMD)
        intrq_r <= 1'b0;
      case (state_r)
        ata_rd_pkg::ST_IDLE:
        begin
          if (wr_cmd && !status_r[ata_rd_pkg::ST_BSY])
          begin
            op_r       <= decode_op(cmd_code);
            error_r    <= 8'h00;
            stop_r     <= 1'b0;
            blk_left_r <= 9'h000;
            remain_r   <= (decode_op(cmd_code) == ata_rd_pkg::OP_LONG) ? 9'h001 : cnt_full;
            if (cmd_code[7:4] == ata_rd_pkg::CMD_RECAL_HI)
            begin
              status_r <= 8'h00;
              intrq_r  <= 1'b1;
            end
            else if ((decode_op(cmd_code) == ata_rd_pkg::OP_DMA
                      && ctrl_r[ata_rd_pkg::CT_BYTE_MODE])
                     || (decode_op(cmd_code) == ata_rd_pkg::OP_MULT
                         && (!blk_set_r || !ctrl_r[ata_rd_pkg::CT_MULT_EN]))
                     || decode_op(cmd_code) == ata_rd_pkg::OP_NONE)
            begin
              error_r[ata_rd_pkg::ER_ABRT] <= 1'b1;
              status_r <= 8'h01;
              intrq_r  <= 1'b1;
            end
            else if (decode_op(cmd_code) == ata_rd_pkg::OP_BUF)
            begin
              // Buffer contents go out as they stand, no media access
              status_r <= 8'h08;
              words_left_r <= ata_rd_pkg::SECTOR_WORDS;
              remain_r <= 9'h001;
              intrq_r  <= 1'b1;
              state_r  <= ata_rd_pkg::ST_XFER;
            end
            else
            begin
              status_r    <= 8'h80;
              media_req_r <= 1'b1;
              state_r     <= ata_rd_pkg::ST_FETCH;
            end
          end
        end
        ata_rd_pkg::ST_FETCH:
        begin
          if (i_media.done)
          begin
            words_left_r <= ata_rd_pkg::SECTOR_WORDS;
            if (i_media.unc_err && op_r != ata_rd_pkg::OP_LONG)
            begin
              error_r[ata_rd_pkg::ER_UNC] <= 1'b1;
              status_r[ata_rd_pkg::ST_ERR] <= 1'b1;
            end
            else if (i_media.corr_err && op_r != ata_rd_pkg::OP_LONG)
              status_r[ata_rd_pkg::ST_CORR] <= 1'b1;
            if (op_r == ata_rd_pkg::OP_VERIFY)
            begin
              if (i_media.unc_err || remain_r == 9'h001)
              begin
                status_r[ata_rd_pkg::ST_BSY] <= 1'b0;
                intrq_r  <= 1'b1;
                state_r  <= ata_rd_pkg::ST_IDLE;
              end
              else
              begin
                remain_r    <= remain_r - 9'h001;
                media_req_r <= 1'b1;
              end
            end
            else
            begin
              // Error stops the command after this sector goes out, or for read multiple after the current block
              if (i_media.unc_err && op_r != ata_rd_pkg::OP_LONG)
                stop_r <= 1'b1;
              status_r[ata_rd_pkg::ST_BSY] <= 1'b0;
              status_r[ata_rd_pkg::ST_DRQ] <= 1'b1;
              state_r <= ata_rd_pkg::ST_XFER;
              if (op_r == ata_rd_pkg::OP_DMA)
              begin
                dmareq_r <= 1'b1;
                if (i_media.unc_err)
                  intrq_r <= 1'b1;
              end
              else if (op_r == ata_rd_pkg::OP_MULT)
              begin
                if (first_sec)
                begin
                  blk_left_r <= (remain_r < {1'b0, blk_size_r}) ? remain_r
                              : {1'b0, blk_size_r};
                  intrq_r    <= 1'b1;
                end
              end
              else
                intrq_r <= 1'b1;
            end
          end
        end
        ata_rd_pkg::ST_XFER:
        begin
          if (word_take)
          begin
            words_left_r <= words_left_r - 9'h001;
            if (words_left_r == 9'h001)
            begin
              if (op_r == ata_rd_pkg::OP_LONG)
              begin
                ecc_idx_r    <= 2'b00;
                words_left_r <= ata_rd_pkg::ECC_BYTES;
                state_r      <= ata_rd_pkg::ST_ECC;
              end
              else
              begin
                remain_r <= remain_r - 9'h001;
                if (op_r == ata_rd_pkg::OP_MULT && blk_left_r != 9'h000)
                  blk_left_r <= blk_left_r - 9'h001;
                if (remain_r == 9'h001
                    || (stop_r && (op_r != ata_rd_pkg::OP_MULT || blk_left_r == 9'h001)))
                begin
                  // Done: flawed data stays in the buffer
                  status_r[ata_rd_pkg::ST_DRQ] <= 1'b0;
                  dmareq_r <= 1'b0;
                  if (op_r == ata_rd_pkg::OP_DMA && !stop_r)
                    intrq_r <= 1'b1;
                  state_r <= ata_rd_pkg::ST_IDLE;
                end
                else
                begin
                  status_r[ata_rd_pkg::ST_DRQ] <= 1'b0;
                  status_r[ata_rd_pkg::ST_BSY] <= 1'b1;
                  dmareq_r    <= 1'b0;
                  media_req_r <= 1'b1;
                  state_r     <= ata_rd_pkg::ST_FETCH;
                end
              end
            end
          end
        end
        ata_rd_pkg::ST_ECC:
        begin
          if (word_take)
          begin
            ecc_idx_r    <= ecc_idx_r + 2'b01;
            words_left_r <= words_left_r - 9'h001;
            if (words_left_r == 9'h001)
              state_r <= ata_rd_pkg::ST_DONE;
          end
        end
        ata_rd_pkg::ST_DONE:
        begin
          status_r[ata_rd_pkg::ST_DRQ] <= 1'b0;
          state_r <= ata_rd_pkg::ST_IDLE;
        end
        default:
          state_r <= ata_rd_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer word index in its own flip-flop so the pin needs no subtractor
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      word_idx_r <= 8'h00;
    else if ((wr_cmd && state_r == ata_rd_pkg::ST_IDLE)
             || (state_r == ata_rd_pkg::ST_FETCH && i_media.done))
      word_idx_r <= 8'h00;
    else if (word_take)
      word_idx_r <= word_idx_r + 8'h01;  // Wraps to zero after the last word
  end

  // DMA data register follows the current word so it is stable at the strobe
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      dma_dat_r <= 16'h0000;
    else
      dma_dat_r <= word_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign o_wb_ack   = ack_r;
  assign o_wb_dat   = rdat_r;
  assign o_media    = '{req: media_req_r, lba: lba};
  assign o_word_idx = word_idx_r;
  assign o_dmareq   = dmareq_r;
  assign o_dma_dat  = dma_dat_r;
  assign o_intrq    = intrq_r;

endmodule // ata_read_command_engine
`default_nettype wire

/* tb/ata_read_command_engine_assertions.sv */
// Port checker for the read command engine, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module ata_rd_checker
(
  // Watched ports
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  input wire logic                   i_wb_cyc,
  input wire logic                   i_wb_stb,
  input wire logic                   i_wb_we,
  input wire logic [5:0]             i_wb_adr,
  input wire logic [31:0]            o_wb_dat,
  input wire logic                   o_wb_ack,
  input wire ata_rd_pkg::media_req_t o_media,
  input wire ata_rd_pkg::media_rsp_t i_media,
  input wire logic                   o_dmareq,
  input wire logic                   i_dmack_n,
  input wire logic                   o_intrq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // A bus request not yet answered
  wire rq = i_wb_cyc && i_wb_stb && !o_wb_ack;
  ////////////////////////////////////////////////////////////////////////////
  chk_ack_next: assert property (rq |=> o_wb_ack) else $error("ack late");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  chk_unmapped_zero: assert property (rq && !i_wb_we && i_wb_adr[5:2] > 4'h9
    |=> o_wb_dat == 32'h0) else $error("unmapped read not zero");
  chk_fill_pulse: assert property (o_media.req |=> !o_media.req)
    else $error("fill request held");
  chk_dreq_cause: assert property ($rose(o_dmareq) |-> $past(i_media.done))
    else $error("dma request without filled buffer");
  chk_dreq_fill: assert property (o_media.req |-> !o_dmareq)
    else $error("dma request during fill");
  // No acknowledge for three cycles means no word was taken
  chk_dreq_hold: assert property (o_dmareq && i_dmack_n && $past(i_dmack_n)
    && $past(i_dmack_n, 2) |=> o_dmareq) else $error("dma request dropped");
  // An unrecoverable error may interrupt while the request still stands
  chk_dma_intr: assert property ($rose(o_intrq)
    |-> !o_dmareq || $past(i_media.unc_err)) else $error("interrupt mid transfer");
  cover property ($rose(o_dmareq));
  cover property ($rose(o_intrq));
  cover property (o_media.req);
endmodule // ata_rd_checker
`default_nettype wire
bind ata_read_command_engine ata_rd_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_media(o_media), .i_media(i_media),
  .o_dmareq(o_dmareq), .i_dmack_n(i_dmack_n), .o_intrq(o_intrq));

/* tb/dma_host_model.sv */
// Host side DMA partner: acknowledges and strobes one read per word
`timescale 1ns/10ps
`default_nettype none
module dma_host_model
(
  // Clock and pace
  input  wire logic        i_clk,
  input  wire logic [3:0]  i_gap,
  // DMA pins
  input  wire logic        i_dmareq,
  input  wire logic [15:0] i_dma_dat,
  output logic             o_dmack_n,
  output logic             o_iord_n
);
  logic [15:0] got[$];
  // Strobes are wide so the card's two-flop synchronisers see each one
  initial
  begin
    o_dmack_n = 1'b1;
    o_iord_n  = 1'b1;
    forever
    begin
      @(posedge i_clk);
      if (i_dmareq === 1'b1)
      begin
        repeat (i_gap) @(posedge i_clk);
        o_dmack_n <= 1'b0;
        while (i_dmareq === 1'b1)
        begin
          repeat (4) @(posedge i_clk);
          got.push_back(i_dma_dat);
          o_iord_n <= 1'b0;
          repeat (4 + i_gap) @(posedge i_clk);
          o_iord_n <= 1'b1;
        end
        o_dmack_n <= 1'b1;
      end
    end
  end
endmodule // dma_host_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the read command engine
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                   i_clk, i_rst_n, cyc, stb, we, ack, dk_n, rd_n, dreq, intrq, irq_q;
  logic [5:0]             adr;
  logic [31:0]            wdat, rdat, q, xs_r;
  logic [15:0]            ddat;
  logic [7:0]             widx, pat;
  logic [3:0]             gap;
  logic [27:0]            exp_lba;
  ata_rd_pkg::media_req_t mreq;
  ata_rd_pkg::media_rsp_t mrsp;
  int                     n_fail, check_count, nsec, bad, dly, k, n_irq;
  ata_read_command_engine u_ata_read_command_engine (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_media(mreq), .i_media(mrsp),
    .i_sector_word({pat, widx}), .i_ecc(32'h44332211), .o_word_idx(widx),
    .o_dmareq(dreq), .i_dmack_n(dk_n), .i_iord_n(rd_n), .o_dma_dat(ddat), .o_intrq(intrq));
  dma_host_model u_dma_host_model (.i_clk(i_clk), .i_gap(gap), .i_dmareq(dreq),
    .i_dma_dat(ddat), .o_dmack_n(dk_n), .o_iord_n(rd_n));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic end_sim();
    $display("fails=%0d checks=%0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 2'b00, d};
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 200);
    // Read data taken and request released at the edge where ack is seen high
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 200)
    begin
      chk(ack, 1);
      end_sim();
    end
  endtask
  // Poll status, bounded
  task automatic wst(input logic [7:0] v);
    int n;
    n = 0;
    do
    begin
      wb(0, 4'h7, 0);
      n++;
    end
    while (q[7:0] !== v && n < 500);
    chk(q[7:0], v);
    if (n >= 500) end_sim();
  endtask
  // Task file at LBA 3123456h, then command
  task automatic cmd(input logic [7:0] c, input logic [7:0] cnt);
    exp_lba = 28'h3123456;
    nsec = 0;
    wb(1, 4'h2, cnt);
    wb(1, 4'h3, 8'h56);
    wb(1, 4'h4, 8'h34);
    wb(1, 4'h5, 8'h12);
    wb(1, 4'h6, 8'hE3);
    wb(1, 4'h7, c);
  endtask
  // Media model: random fill time and pattern, optional failing sector
  always @(posedge i_clk)
  begin
    if (mreq.req === 1'b1)
    begin
      mrsp.done <= 1'b0;
      chk({4'h0, mreq.lba}, {4'h0, exp_lba});
      exp_lba <= exp_lba + 28'h1;
      xs_r <= xs(xs_r);
      pat <= xs_r[15:8];
      dly <= 2 + xs_r[2:0];
    end
    else if (dly == 1)
    begin
      mrsp <= {1'b1, 1'b0, nsec == bad};
      nsec <= nsec + 1;
      dly <= 0;
    end
    else
    begin
      // Done is a one-cycle pulse; error bits matter only with it
      mrsp.done <= 1'b0;
      if (dly > 1)
        dly <= dly - 1;
    end
  end
  // Interrupt rises, counted for the one-per-block check
  always @(posedge i_clk)
  begin
    irq_q <= intrq;
    if (intrq === 1'b1 && irq_q !== 1'b1)
      n_irq <= n_irq + 1;
  end
  // One sector of data words by PIO, compared with the media pattern
  task automatic rd_sec();
    for (int i = 0; i < 256; i++)
    begin
      wb(0, 4'h0, 0);
      chk(q[15:0], {pat, i[7:0]});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {cyc, stb, we, adr, wdat, mrsp, pat, gap, dly} = '0;
    {n_fail, check_count} = '0;
    xs_r = 32'h0000C0C3;
    bad = -1;
    i_rst_n = 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wb(0, 4'h6, 0);
    chk(q[7:0], 8'hA0);
    wb(0, 4'hC, 0);
    chk(q, 0);
    cmd(8'hC4, 8'h02);
    wst(8'h01);
    wb(1, 4'h8, 1);
    cmd(8'hC8, 8'h01);
    wst(8'h01);
    wb(0, 4'h9, 0);
    chk(q[2], 1);
    wb(1, 4'h8, 0);
    for (k = 0; k < 16; k++)
    begin
      wb(1, 4'h7, 8'h10 | k[7:0]);
      wst(8'h00);
    end
    cmd(8'h20, 8'h02);
    repeat (2)
    begin
      wst(8'h08);
      rd_sec();
    end
    wst(8'h00);
    wb(0, 4'h3, 0);
    chk(q[7:0], 8'h57);
    cmd(8'h22, 8'h00);
    wst(8'h08);
    rd_sec();
    for (k = 1; k < 5; k++)
    begin
      wb(0, 4'h0, 0);
      chk(q, 32'h11 * k);
    end
    wst(8'h00);
    wb(1, 4'h7, 8'hE4);
    wst(8'h08);
    rd_sec();
    wst(8'h00);
    wb(1, 4'h8, 32'h0000_0202);
    n_irq = 0;
    cmd(8'hC4, 8'h03);
    repeat (3)
    begin
      wst(8'h08);
      rd_sec();
    end
    wst(8'h00);
    chk(n_irq, 2);
    bad = 1;
    cmd(8'h40, 8'h03);
    wst(8'h01);
    wb(0, 4'h2, 0);
    chk(q[7:0], 8'h02);
    wb(0, 4'h3, 0);
    chk(q[7:0], 8'h57);
    bad = -1;
    gap <= 4'h3;
    cmd(8'hC8, 8'h01);
    for (k = 0; k < 20000 && intrq !== 1'b1; k++) @(posedge i_clk);
    chk(intrq, 1);
    chk(32'(u_dma_host_model.got.size()), 256);
    for (k = 0; k < 256; k++) chk(u_dma_host_model.got[k], {pat, k[7:0]});
    end_sim();
  end
endmodule // testbench
`default_nettype wire
